// file: shared/drw_map.svh
// Purpose: register offsets, field positions and reset values
// Assumes: one 32-bit register per aligned word
// Notes: definitions only
`ifndef DRW_MAP_SVH
`define DRW_MAP_SVH

`define DRW_ADDR_W 8
`define DRW_OFS_AREA_CTL 8'h00
`define DRW_OFS_CHAN_CTL 8'h04
`define DRW_OFS_IRQ_STAT 8'h08
`define DRW_OFS_IRQ_MASK 8'h0C
`define DRW_OFS_SRC_ADDR 8'h10
`define DRW_OFS_DST_ADDR 8'h14

`define DRW_SRC_IE_BIT 15
`define DRW_SRC_SIZE_HI 12
`define DRW_SRC_SIZE_LO 8
`define DRW_DST_IE_BIT 7
`define DRW_DST_SIZE_HI 4
`define DRW_DST_SIZE_LO 0

`define DRW_TE_BIT 0
`define DRW_FLAG_BIT 1

`define DRW_ST_SRC_OVF 0
`define DRW_ST_DST_OVF 1
`define DRW_ST_STOP 2

`define DRW_AREA_MAX 5'h1B
`define DRW_RST_SIZE 5'h00
`define DRW_RST_ADDR 32'h00000000
`define DRW_RST_BITS 3'h0

`endif

// file: shared/drw_pkg.sv
// Purpose: types and area decode for the repeat-area wrap block
// Assumes: drw_map.svh on the include path
// Notes: nothing here holds state
`default_nettype none
`include "drw_map.svh"

package drw_pkg;

    typedef enum logic [0:0] {
        DRW_RUN,
        DRW_DEFER
    } drw_phase_t;

    typedef struct packed {
        logic [4:0] src_size;
        logic src_ie;
        logic [4:0] dst_size;
        logic dst_ie;
        logic te;
        logic flag;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [31:0] rdata;
        drw_phase_t phase;
    } drw_state_t;

    // low-bit mask of the area; zero for none or a prohibited code
    function automatic logic [31:0] area_mask(input logic [4:0] code);
        logic [31:0] m;
        m = 32'h00000000;
        if (code != 5'h00 && code <= `DRW_AREA_MAX)
        begin
            m = (32'h00000001 << code) - 32'h00000001;
        end
        return m;
    endfunction : area_mask

endpackage : drw_pkg

`default_nettype wire

// file: src/drw_addr_wrap.sv
// Purpose: one address step with repeat-area wrap
// Assumes: step of 1, 2 or 4 bytes by access size
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module drw_addr_wrap (
    input wire logic [31:0] addr_i,
    input wire logic [1:0] size_i,
    input wire logic dec_i,
    input wire logic [4:0] area_code_i,
    output logic [31:0] addr_o,
    output logic ovf_o
);

    logic [31:0] mask;
    logic [31:0] step;
    logic [31:0] sum;

    always_comb
    begin
        mask = drw_pkg::area_mask(area_code_i);
        case (size_i)
            2'h0: step = 32'h00000001;
            2'h1: step = 32'h00000002;
            default: step = 32'h00000004;
        endcase
        sum = dec_i ? (addr_i - step) : (addr_i + step);
        // a carry out of the low bits leaves the area
        ovf_o = (mask != 32'h00000000) &&
                ((sum & ~mask) != (addr_i & ~mask));
        // no carry out: high bits already match, or no area
        if (!ovf_o)
        begin
            addr_o = sum;
        end
        else if (dec_i)
        begin
            addr_o = addr_i | mask;
        end
        else
        begin
            addr_o = addr_i & ~mask;
        end
    end

endmodule : drw_addr_wrap

`default_nettype wire

// file: src/drw_top.sv
// Purpose: per-channel repeat-area wrap, overflow stop and registers
// Assumes: sequencer pulses one update per transferred unit
// Notes: plain register port, read data one cycle after the strobe
//
// Notes on behaviour
// - source area size field in bits 12..8
// - destination area size field in bits 4..0
// - inside an area only low bits change
// - area sizes are powers of two bytes
// - overflow wraps to area start or end
// - source overflow may request interrupt when enabled
// - enabled destination overflow clears transfer enable
// - that overflow sets the overflow status flag
// - block mode defers request until block ends
// - re-enabling resumes from the stopped state
// - no destination area ignores its enable
// - destination enable low means no request
// - bits 6 and 5 read zero
// - size code decode, 111xx prohibited
// - enabled source overflow stops and flags
`timescale 1ns/1ps
`default_nettype none
`include "drw_map.svh"

module drw_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic src_upd_i,
    input wire logic src_dec_i,
    input wire logic dst_upd_i,
    input wire logic dst_dec_i,
    input wire logic [1:0] access_size_i,
    input wire logic block_mode_i,
    input wire logic block_done_i,
    output logic [31:0] src_addr_o,
    output logic [31:0] dst_addr_o,
    output logic channel_transfer_enable_o,
    output logic area_overflow_status_flag_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // state and wrap paths
    // ------------------------------------------------------------
    drw_pkg::drw_state_t q;
    drw_pkg::drw_state_t d;

    logic [31:0] cur_addr [2];
    logic [31:0] nxt_addr [2];
    logic [4:0] area_code [2];
    logic dec_sel [2];
    logic ovf [2];

    assign cur_addr[0] = q.src_addr;
    assign cur_addr[1] = q.dst_addr;
    assign area_code[0] = q.src_size;
    assign area_code[1] = q.dst_size;
    assign dec_sel[0] = src_dec_i;
    assign dec_sel[1] = dst_dec_i;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_wrap
            drw_addr_wrap u_wrap (
                .addr_i(cur_addr[gi]),
                .size_i(access_size_i),
                .dec_i(dec_sel[gi]),
                .area_code_i(area_code[gi]),
                .addr_o(nxt_addr[gi]),
                .ovf_o(ovf[gi])
            );
        end
    endgenerate

    logic src_ev;
    logic dst_ev;
    logic src_req;
    logic dst_req;
    logic stop_req;

    always_comb
    begin
        src_ev = q.te && src_upd_i && ovf[0];
        dst_ev = q.te && dst_upd_i && ovf[1];
        // enable counts only with an area selected
        src_req = src_ev && q.src_ie &&
                  (drw_pkg::area_mask(q.src_size) != 32'h00000000);
        dst_req = dst_ev && q.dst_ie &&
                  (drw_pkg::area_mask(q.dst_size) != 32'h00000000);
        stop_req = src_req || dst_req;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.rdata = 32'h00000000;

        // register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `DRW_OFS_AREA_CTL:
                begin
                    d.src_size = reg_wdata_i[`DRW_SRC_SIZE_HI:`DRW_SRC_SIZE_LO];
                    d.src_ie = reg_wdata_i[`DRW_SRC_IE_BIT];
                    d.dst_size = reg_wdata_i[`DRW_DST_SIZE_HI:`DRW_DST_SIZE_LO];
                    d.dst_ie = reg_wdata_i[`DRW_DST_IE_BIT];
                end
                `DRW_OFS_CHAN_CTL:
                begin
                    d.te = reg_wdata_i[`DRW_TE_BIT];
                    if (!reg_wdata_i[`DRW_FLAG_BIT])
                    begin
                        d.flag = 1'b0;
                    end
                end
                `DRW_OFS_IRQ_MASK: d.mask = reg_wdata_i[2:0];
                `DRW_OFS_SRC_ADDR: d.src_addr = reg_wdata_i;
                `DRW_OFS_DST_ADDR: d.dst_addr = reg_wdata_i;
                default: d.rdata = 32'h00000000;
            endcase
        end

        // register reads
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `DRW_OFS_AREA_CTL:
                begin
                    d.rdata[`DRW_SRC_IE_BIT] = q.src_ie;
                    d.rdata[`DRW_SRC_SIZE_HI:`DRW_SRC_SIZE_LO] = q.src_size;
                    d.rdata[`DRW_DST_IE_BIT] = q.dst_ie;
                    d.rdata[`DRW_DST_SIZE_HI:`DRW_DST_SIZE_LO] = q.dst_size;
                    // bits 6 and 5 stay zero
                    d.rdata[6:5] = 2'h0;
                end
                `DRW_OFS_CHAN_CTL:
                begin
                    d.rdata[`DRW_TE_BIT] = q.te;
                    d.rdata[`DRW_FLAG_BIT] = q.flag;
                end
                `DRW_OFS_IRQ_STAT:
                begin
                    d.rdata[2:0] = q.stat;
                    d.stat = `DRW_RST_BITS;
                end
                `DRW_OFS_IRQ_MASK: d.rdata[2:0] = q.mask;
                `DRW_OFS_SRC_ADDR: d.rdata = q.src_addr;
                `DRW_OFS_DST_ADDR: d.rdata = q.dst_addr;
                default: d.rdata = 32'h00000000;
            endcase
        end

        // address updates, wrap inside the area
        if (q.te && src_upd_i)
        begin
            d.src_addr = nxt_addr[0];
        end
        if (q.te && dst_upd_i)
        begin
            d.dst_addr = nxt_addr[1];
        end

        // overflow stop, deferred in block mode
        case (q.phase)
            drw_pkg::DRW_RUN:
            begin
                if (stop_req && (!block_mode_i || block_done_i))
                begin
                    d.te = 1'b0;
                    d.flag = 1'b1;
                end
                else if (stop_req)
                begin
                    d.phase = drw_pkg::DRW_DEFER;
                end
            end
            drw_pkg::DRW_DEFER:
            begin
                if (block_done_i)
                begin
                    d.te = 1'b0;
                    d.flag = 1'b1;
                    d.phase = drw_pkg::DRW_RUN;
                end
            end
            default: d.phase = drw_pkg::DRW_RUN;
        endcase

        // events set status after any read clear
        if (src_ev)
        begin
            d.stat[`DRW_ST_SRC_OVF] = 1'b1;
        end
        if (dst_ev)
        begin
            d.stat[`DRW_ST_DST_OVF] = 1'b1;
        end
        if (d.flag && !q.flag)
        begin
            d.stat[`DRW_ST_STOP] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            q.src_size <= `DRW_RST_SIZE;
            q.src_ie <= 1'b0;
            q.dst_size <= `DRW_RST_SIZE;
            q.dst_ie <= 1'b0;
            q.te <= 1'b0;
            q.flag <= 1'b0;
            q.stat <= `DRW_RST_BITS;
            q.mask <= `DRW_RST_BITS;
            q.src_addr <= `DRW_RST_ADDR;
            q.dst_addr <= `DRW_RST_ADDR;
            q.rdata <= `DRW_RST_ADDR;
            q.phase <= drw_pkg::DRW_RUN;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign src_addr_o = q.src_addr;
    assign dst_addr_o = q.dst_addr;
    assign channel_transfer_enable_o = q.te;
    assign area_overflow_status_flag_o = q.flag;
    assign irq_o = |(q.stat & q.mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ctl_write;
        reg_wr_i && reg_addr_i == `DRW_OFS_AREA_CTL;
    endsequence

    sequence s_defer_start;
        q.phase == drw_pkg::DRW_RUN && stop_req && block_mode_i &&
            !block_done_i && !reg_wr_i;
    endsequence

    sequence s_defer_end;
        q.phase == drw_pkg::DRW_DEFER && block_done_i;
    endsequence

    chk_src_field_map: assert property (
        s_ctl_write |=> q.src_size == $past(reg_wdata_i[12:8]))
        else $error("source area size field not stored");

    chk_dst_field_map: assert property (
        s_ctl_write |=> q.dst_size == $past(reg_wdata_i[4:0]))
        else $error("destination area size field not stored");

    chk_high_bits_hold: assert property (
        (q.te && dst_upd_i && !reg_wr_i &&
            drw_pkg::area_mask(q.dst_size) != 32'h00000000) |=>
            ((dst_addr_o ^ $past(dst_addr_o)) &
                ~drw_pkg::area_mask(q.dst_size)) == 32'h00000000)
        else $error("high address bits moved inside the area");

    chk_wrap_to_start: assert property (
        (q.te && src_upd_i && ovf[0] && !src_dec_i && !reg_wr_i) |=>
            (src_addr_o & drw_pkg::area_mask(q.src_size)) == 32'h00000000)
        else $error("incrementing overflow did not wrap to start");

    chk_dst_stop_te: assert property (
        (dst_req && !block_mode_i && q.phase == drw_pkg::DRW_RUN) |=>
            !channel_transfer_enable_o)
        else $error("destination overflow left channel enabled");

    chk_dst_stop_flag: assert property (
        (dst_req && !block_mode_i && q.phase == drw_pkg::DRW_RUN) |=>
            area_overflow_status_flag_o)
        else $error("destination overflow did not set the flag");

    chk_defer_block: assert property (
        s_defer_start |=> q.phase == drw_pkg::DRW_DEFER &&
            channel_transfer_enable_o)
        else $error("block mode stop was not deferred");

    chk_defer_release: assert property (
        s_defer_end |=> !channel_transfer_enable_o &&
            area_overflow_status_flag_o && q.phase == drw_pkg::DRW_RUN)
        else $error("deferred stop not taken at block end");

    chk_no_dst_area: assert property (
        (q.dst_size == 5'h00 && q.dst_ie && q.te && dst_upd_i &&
            !src_upd_i && !reg_wr_i && q.phase == drw_pkg::DRW_RUN) |=>
            channel_transfer_enable_o)
        else $error("enable acted without a destination area");

    chk_ie_off_runs: assert property (
        (q.te && !q.src_ie && !q.dst_ie && !reg_wr_i &&
            q.phase == drw_pkg::DRW_RUN) |=>
            channel_transfer_enable_o)
        else $error("channel stopped with interrupts disabled");

    chk_reserved_zero: assert property (
        (reg_rd_i && reg_addr_i == `DRW_OFS_AREA_CTL) |=>
            reg_rdata_o[6:5] == 2'h0)
        else $error("reserved bits read nonzero");

    chk_src_stop: assert property (
        (src_req && !block_mode_i && q.phase == drw_pkg::DRW_RUN) |=>
            !channel_transfer_enable_o && area_overflow_status_flag_o)
        else $error("source overflow did not stop the channel");

endmodule : drw_top

`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for the repeat-area wrap block
// Assumes: register map from drw_map.svh, strobes driven on rising edges
// Notes: no random stimulus
`timescale 1ns/1ps
`default_nettype none
`include "drw_map.svh"

module tb_top;

// ----------------------------------------
// signals
// ----------------------------------------
logic ref_clk_i = 1'b0;
logic rst_i = 1'b1;
logic [7:0] reg_addr_i = 8'h00;
logic [31:0] reg_wdata_i = 32'h00000000;
logic reg_wr_i = 1'b0;
logic reg_rd_i = 1'b0;
logic [31:0] reg_rdata_o;
logic src_upd_i = 1'b0;
logic src_dec_i = 1'b0;
logic dst_upd_i = 1'b0;
logic dst_dec_i = 1'b0;
logic [1:0] access_size_i = 2'h0;
logic block_mode_i = 1'b0;
logic block_done_i = 1'b0;
logic [31:0] src_addr_o;
logic [31:0] dst_addr_o;
logic te;
logic flag;
logic irq;
int err_total = 0;
int tests_run = 0;

drw_top dut (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .src_upd_i(src_upd_i),
    .src_dec_i(src_dec_i),
    .dst_upd_i(dst_upd_i),
    .dst_dec_i(dst_dec_i),
    .access_size_i(access_size_i),
    .block_mode_i(block_mode_i),
    .block_done_i(block_done_i),
    .src_addr_o(src_addr_o),
    .dst_addr_o(dst_addr_o),
    .channel_transfer_enable_o(te),
    .area_overflow_status_flag_o(flag),
    .irq_o(irq)
);

initial
begin
    forever #20 ref_clk_i = ~ref_clk_i;
end

// ----------------------------------------
// tasks
// ----------------------------------------
task automatic final_report;
    if (err_total == 0 && tests_run > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask : final_report

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
        err_total++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask : chk

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
endtask : wr

task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
endtask : rd

task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
endtask : rd_chk

// one unit update on source or destination, outputs settled after
task automatic upd(input logic is_dst, input logic dec);
    @(posedge ref_clk_i);
    if (is_dst)
    begin
        dst_upd_i <= 1'b1;
        dst_dec_i <= dec;
    end
    else
    begin
        src_upd_i <= 1'b1;
        src_dec_i <= dec;
    end
    @(posedge ref_clk_i);
    dst_upd_i <= 1'b0;
    src_upd_i <= 1'b0;
    #1;
endtask : upd

task automatic chk_ctl(input logic t, input logic f);
    chk({30'h0, te, flag}, {30'h0, t, f});
endtask : chk_ctl

function automatic logic [31:0] ctl(input logic sie, input logic [4:0] ssz,
    input logic die, input logic [4:0] dsz);
    return {16'h0000, sie, 2'b00, ssz, die, 2'b00, dsz};
endfunction : ctl

// ----------------------------------------
// watchdog
// ----------------------------------------
initial
begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    final_report();
end

// ----------------------------------------
// tests
// ----------------------------------------
initial
begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
        rd_chk(8'(i * 4), 32'h00000000);
    end
    chk({31'h0, irq}, 32'h00000000);
    // field placement and reserved bits
    wr(`DRW_OFS_AREA_CTL, 32'hFFFFFFFF);
    rd_chk(`DRW_OFS_AREA_CTL, 32'h00009F9F);
    rd_chk(8'h20, 32'h00000000);
    // destination wrap with stop and flag
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b1, 5'h02));
    wr(`DRW_OFS_DST_ADDR, 32'h00000103);
    wr(`DRW_OFS_IRQ_MASK, 32'h00000007);
    wr(`DRW_OFS_CHAN_CTL, 32'h00000001);
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000100);
    chk_ctl(1'b0, 1'b1);
    chk({31'h0, irq}, 32'h00000001);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000006);
    chk({31'h0, irq}, 32'h00000000);
    // stopped channel holds, then resumes
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000100);
    wr(`DRW_OFS_CHAN_CTL, 32'h00000001);
    chk_ctl(1'b1, 1'b0);
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000101);
    // source decrement wrap, enable low, masked interrupt
    wr(`DRW_OFS_IRQ_MASK, 32'h00000000);
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h03, 1'b0, 5'h00));
    wr(`DRW_OFS_SRC_ADDR, 32'h20000000);
    upd(1'b0, 1'b1);
    chk(src_addr_o, 32'h20000007);
    chk_ctl(1'b1, 1'b0);
    chk({31'h0, irq}, 32'h00000000);
    wr(`DRW_OFS_IRQ_MASK, 32'h00000007);
    #1;
    chk({31'h0, irq}, 32'h00000001);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000001);
    // source overflow with enable stops
    wr(`DRW_OFS_AREA_CTL, ctl(1'b1, 5'h03, 1'b0, 5'h00));
    upd(1'b0, 1'b0);
    chk(src_addr_o, 32'h20000000);
    chk_ctl(1'b0, 1'b1);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000005);
    wr(`DRW_OFS_CHAN_CTL, 32'h00000001);
    // destination enable low, 4-byte steps
    access_size_i <= 2'h2;
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b0, 5'h02));
    wr(`DRW_OFS_DST_ADDR, 32'h000001FC);
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h000001FC);
    chk_ctl(1'b1, 1'b0);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000002);
    // no area: enable ignored, no wrap
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b1, 5'h00));
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000200);
    chk_ctl(1'b1, 1'b0);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000000);
    // prohibited code behaves as no area
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b1, 5'h1C));
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000204);
    chk_ctl(1'b1, 1'b0);
    access_size_i <= 2'h1;
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h00000206);
    access_size_i <= 2'h2;
    // largest area, upper bits held
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b1, 5'h1B));
    wr(`DRW_OFS_DST_ADDR, 32'hF7FFFFFC);
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'hF0000000);
    chk_ctl(1'b0, 1'b1);
    wr(`DRW_OFS_CHAN_CTL, 32'h00000001);
    rd_chk(`DRW_OFS_IRQ_STAT, 32'h00000006);
    // block mode defers the stop to block end
    block_mode_i <= 1'b1;
    wr(`DRW_OFS_AREA_CTL, ctl(1'b0, 5'h00, 1'b1, 5'h02));
    wr(`DRW_OFS_DST_ADDR, 32'h000001FC);
    upd(1'b1, 1'b0);
    chk(dst_addr_o, 32'h000001FC);
    chk_ctl(1'b1, 1'b0);
    @(posedge ref_clk_i);
    block_done_i <= 1'b1;
    @(posedge ref_clk_i);
    block_done_i <= 1'b0;
    #1;
    chk_ctl(1'b0, 1'b1);
    block_mode_i <= 1'b0;
    rd_chk(`DRW_OFS_CHAN_CTL, 32'h00000002);
    final_report();
end

endmodule : tb_top

`default_nettype wire
